// *** design/word_exchange_pkg.sv ***
/*
 * Constants shared by the word-exchange block and its setting store.
 * Assumes a host word memory answering one word request at a time.
 */
// Behaviour
// - cyclic block is ten words starting at 2000 plus ten times unit number
// - parameter block is 100 words starting at 20000 plus 100 times unit number
// - unit number from switches, 0 to 95, selects both blocks
// - first parameter word 12345 at start-up copies internal settings to host
// - first word other than 12345 at start-up loads settings from host
// - input unit continuously writes process values, alarms, disconnection flags
// - output unit continuously reads its output values from host
// - refreshed settings group re-read every pass, and at start-up unless command word is 12345
// - initial settings group loaded once per start-up, unless command word is 12345
// - error lamp lights when any setting is out of range
// - error word holds offset of first faulty word, four hex digits
// - refreshed group range errors shown and stored at once
// - initial group range errors shown and stored only at next start-up
// - after copy-back, first parameter word is cleared to zero
package word_exchange_pkg;
  // ==========================================================
  // word map
  localparam logic [15:0] CYCLIC_BASE = 16'h07D0;
  localparam logic [15:0] CYCLIC_STRIDE = 16'h000A;
  localparam logic [15:0] PARAM_BASE = 16'h4E20;
  localparam logic [15:0] PARAM_STRIDE = 16'h0064;
  localparam logic [6:0] MAX_UNIT = 7'h5F;
  localparam int CYC_WORDS = 10;
  // ==========================================================
  // parameter block layout, offsets from its first word
  localparam logic [6:0] CMD_OFS = 7'h00;
  localparam logic [6:0] G1_FIRST = 7'h01;
  localparam logic [6:0] G1_LAST = 7'h08;
  localparam logic [6:0] G2_FIRST = 7'h09;
  localparam logic [6:0] G2_LAST = 7'h10;
  localparam logic [6:0] ERR_OFS = 7'h11;
  localparam int SET_WORDS = 16;
  // ==========================================================
  // values
  localparam logic [15:0] COPY_BACK_CMD = 16'h3039;
  localparam logic [15:0] SETTING_MAX = 16'h270F;
  localparam logic [15:0] SETTING_RESET = 16'h0000;
  localparam logic AREA_CYCLIC = 1'b0;
  localparam logic AREA_PARAM = 1'b1;

  typedef enum logic [2:0] {
    ST_START = 3'h0,
    ST_LOAD = 3'h1,
    ST_ERRWR = 3'h3,
    ST_G1 = 3'h2,
    ST_CYC = 3'h6,
    ST_COPY = 3'h7,
    ST_CLRCMD = 3'h5,
    ST_HALT = 3'h4
  } state_t;

  function automatic logic [15:0] word_addr(input logic [15:0] base, input logic [15:0] stride,
                                            input logic [6:0] unit, input logic [6:0] ofs);
    logic [31:0] prod;
    prod = stride * {9'h000, unit};
    word_addr = base + prod[15:0] + {9'h000, ofs};
  endfunction
endpackage

// *** design/setting_if.sv ***
/*
 * Carrier between the exchange sequencer and its setting store.
 * Assumes both ends share one clock.
 */
interface setting_if;
  logic wr;
  logic [6:0] idx;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic bad;
  modport store (input wr, input idx, input wdata, output rdata, output bad);
  modport ctrl (output wr, output idx, output wdata, input rdata, input bad);
endinterface

// *** design/setting_store.sv ***
/*
 * Holds the unit's setting words of both groups and checks incoming values.
 * Assumes the sequencer writes only words it has just read from the host.
 */
module setting_store (
  input wire logic clock_in,
  input wire logic rst_n_in,
  setting_if.store port
);
  import word_exchange_pkg::*;

  logic [15:0] mem_q [SET_WORDS];

  // out-of-range words are flagged and not taken, last good value stays
  assign port.bad = port.wdata > SETTING_MAX;
  assign port.rdata = mem_q[port.idx[3:0]];

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < SET_WORDS; i++) begin
        mem_q[i] <= SETTING_RESET;
      end
    end else if (port.wr && !port.bad) begin
      mem_q[port.idx[3:0]] <= port.wdata;
    end
  end
endmodule // setting_store

// *** design/io_unit_shared_word_exchange.sv ***
/*
 * Word-exchange sequencer of a plug-in unit: start-up load or copy-back,
 * then endless refresh of setting group 1 and the cyclic words.
 * Assumes the host memory answers each request with a one-cycle ack.
 */
module io_unit_shared_word_exchange
#(
  parameter bit IS_INPUT = 1'b1
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic restart_in,
  input wire logic [6:0] unit_number_in,
  input wire logic [15:0] proc_in [word_exchange_pkg::CYC_WORDS],
  input wire logic ack_in,
  input wire logic [15:0] rdata_in,
  output logic req_out,
  output logic we_out,
  output logic area_out,
  output logic [15:0] addr_out,
  output logic [15:0] wdata_out,
  output logic unit_error_lamp_out,
  output logic unit_number_bad_out,
  output logic [15:0] cyc_out [word_exchange_pkg::CYC_WORDS]
);
  import word_exchange_pkg::*;

  state_t state_q;
  logic [6:0] cnt_q;
  logic [6:0] unit_q;
  logic req_q;
  logic we_q;
  logic area_q;
  logic [15:0] addr_q;
  logic [15:0] wdata_q;
  logic pass_err_q;
  logic [6:0] pass_ofs_q;
  logic g2_err_q;
  logic [6:0] g2_ofs_q;
  logic lamp_q;
  logic bad_unit_q;
  logic [15:0] cyc_q [CYC_WORDS];
  logic done;
  logic in_g1;
  logic in_g2;
  logic [15:0] err_word;

  setting_if sif ();

  setting_store u_store (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .port(sif.store)
  );

  assign done = req_q && ack_in;
  assign in_g1 = (cnt_q >= G1_FIRST) && (cnt_q <= G1_LAST);
  assign in_g2 = (cnt_q >= G2_FIRST) && (cnt_q <= G2_LAST);
  assign sif.wr = done && ((state_q == ST_LOAD) || (state_q == ST_G1));
  assign sif.idx = cnt_q - G1_FIRST;
  assign sif.wdata = rdata_in;

  // lowest offset wins: group 1 sits below group 2 in the block
  always_comb begin
    if (pass_err_q) begin
      err_word = {9'h000, pass_ofs_q};
    end else if (g2_err_q) begin
      err_word = {9'h000, g2_ofs_q};
    end else begin
      err_word = 16'h0000;
    end
  end

  // ==========================================================
  // sequencer and host word port
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      state_q <= ST_START;
      cnt_q <= 7'h00;
      unit_q <= 7'h00;
      req_q <= 1'b0;
      we_q <= 1'b0;
      area_q <= AREA_PARAM;
      addr_q <= 16'h0000;
      wdata_q <= 16'h0000;
      bad_unit_q <= 1'b0;
    end else if (restart_in) begin
      // the host's restart bit reruns start-up but keeps stored settings, lamp and output values
      state_q <= ST_START;
      req_q <= 1'b0;
      we_q <= 1'b0;
    end else if (!req_q) begin
      case (state_q)
        ST_START: begin
          unit_q <= unit_number_in;
          cnt_q <= CMD_OFS;
          if (unit_number_in > MAX_UNIT) begin
            // an illegal switch setting must never touch another unit's words
            bad_unit_q <= 1'b1;
            state_q <= ST_HALT;
          end else begin
            bad_unit_q <= 1'b0;
            req_q <= 1'b1;
            we_q <= 1'b0;
            area_q <= AREA_PARAM;
            addr_q <= word_addr(PARAM_BASE, PARAM_STRIDE, unit_number_in, CMD_OFS);
          end
        end
        ST_LOAD, ST_G1: begin
          req_q <= 1'b1;
          we_q <= 1'b0;
          area_q <= AREA_PARAM;
          addr_q <= word_addr(PARAM_BASE, PARAM_STRIDE, unit_q, cnt_q);
        end
        ST_COPY: begin
          req_q <= 1'b1;
          we_q <= 1'b1;
          area_q <= AREA_PARAM;
          addr_q <= word_addr(PARAM_BASE, PARAM_STRIDE, unit_q, cnt_q);
          wdata_q <= sif.rdata;
        end
        ST_CLRCMD: begin
          req_q <= 1'b1;
          we_q <= 1'b1;
          area_q <= AREA_PARAM;
          addr_q <= word_addr(PARAM_BASE, PARAM_STRIDE, unit_q, CMD_OFS);
          wdata_q <= 16'h0000;
        end
        ST_ERRWR: begin
          req_q <= 1'b1;
          we_q <= 1'b1;
          area_q <= AREA_PARAM;
          addr_q <= word_addr(PARAM_BASE, PARAM_STRIDE, unit_q, ERR_OFS);
          wdata_q <= err_word;
        end
        ST_CYC: begin
          req_q <= 1'b1;
          we_q <= IS_INPUT;
          area_q <= AREA_CYCLIC;
          addr_q <= word_addr(CYCLIC_BASE, CYCLIC_STRIDE, unit_q, cnt_q);
          wdata_q <= proc_in[cnt_q[3:0]];
        end
        default: begin
          req_q <= 1'b0;
        end
      endcase
    end else if (ack_in) begin
      req_q <= 1'b0;
      case (state_q)
        ST_START: begin
          cnt_q <= G1_FIRST;
          // anything but the copy-back code loads from the host
          if (rdata_in == COPY_BACK_CMD) begin
            state_q <= ST_COPY;
          end else begin
            state_q <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (cnt_q == G2_LAST) begin
            state_q <= ST_ERRWR;
          end else begin
            cnt_q <= cnt_q + 7'h01;
          end
        end
        ST_COPY: begin
          if (cnt_q == G2_LAST) begin
            state_q <= ST_CLRCMD;
          end else begin
            cnt_q <= cnt_q + 7'h01;
          end
        end
        ST_CLRCMD, ST_ERRWR: begin
          cnt_q <= G1_FIRST;
          state_q <= ST_G1;
        end
        ST_G1: begin
          if (cnt_q == G1_LAST) begin
            cnt_q <= 7'h00;
            state_q <= ST_CYC;
          end else begin
            cnt_q <= cnt_q + 7'h01;
          end
        end
        ST_CYC: begin
          if (cnt_q == 7'(CYC_WORDS - 1)) begin
            state_q <= ST_ERRWR;
          end else begin
            cnt_q <= cnt_q + 7'h01;
          end
        end
        default: begin
          state_q <= state_q;
        end
      endcase
    end
  end

  // ==========================================================
  // range errors
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      pass_err_q <= 1'b0;
      pass_ofs_q <= 7'h00;
      g2_err_q <= 1'b0;
      g2_ofs_q <= 7'h00;
      lamp_q <= 1'b0;
    end else if (restart_in || (done && state_q == ST_START)) begin
      // group 2 verdict is only renewed by a start-up
      pass_err_q <= 1'b0;
      g2_err_q <= 1'b0;
    end else if (done) begin
      if (sif.wr && in_g1 && sif.bad && !pass_err_q) begin
        pass_err_q <= 1'b1;
        pass_ofs_q <= cnt_q;
      end
      if (state_q == ST_LOAD && in_g2 && sif.bad && !g2_err_q) begin
        g2_err_q <= 1'b1;
        g2_ofs_q <= cnt_q;
      end
      if (state_q == ST_ERRWR) begin
        lamp_q <= pass_err_q || g2_err_q;
        pass_err_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // output values taken from the host
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < CYC_WORDS; i++) begin
        cyc_q[i] <= 16'h0000;
      end
    end else if (done && state_q == ST_CYC && !IS_INPUT) begin
      cyc_q[cnt_q[3:0]] <= rdata_in;
    end
  end

  assign req_out = req_q;
  assign we_out = we_q;
  assign area_out = area_q;
  assign addr_out = addr_q;
  assign wdata_out = wdata_q;
  assign unit_error_lamp_out = lamp_q;
  assign unit_number_bad_out = bad_unit_q;
  assign cyc_out = cyc_q;
endmodule // io_unit_shared_word_exchange

// *** dv/word_exchange_monitor.sv ***
/* port checker for the word-exchange block
   assumes the unit number is held steady except across restart */
module word_exchange_monitor
#(
  parameter bit IS_INPUT = 1'b1
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic restart_in,
  input wire logic [6:0] unit_number_in,
  input wire logic ack_in,
  input wire logic [15:0] rdata_in,
  input wire logic req_out,
  input wire logic we_out,
  input wire logic area_out,
  input wire logic [15:0] addr_out,
  input wire logic [15:0] wdata_out,
  input wire logic unit_error_lamp_out,
  input wire logic unit_number_bad_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import word_exchange_pkg::*;
  // ==========================================
  // helpers
  logic [15:0] cb;
  logic [15:0] pb;
  logic take;
  assign cb = CYCLIC_BASE + CYCLIC_STRIDE * {9'h000, unit_number_in};
  assign pb = PARAM_BASE + PARAM_STRIDE * {9'h000, unit_number_in};
  assign take = req_out && ack_in;
  default clocking cb_clk @(posedge clock_in); endclocking
  default disable iff (!rst_n_in || restart_in);
  // ==========================================
  // properties
  sequence s_cmd_rd;
    take && !we_out && area_out && addr_out == pb;
  endsequence
  property p_copy;
    s_cmd_rd ##0 rdata_in == COPY_BACK_CMD |-> ##2 req_out && we_out && addr_out == pb + 16'h0001;
  endproperty
  property p_load;
    s_cmd_rd ##0 rdata_in != COPY_BACK_CMD |-> ##2 req_out && !we_out && addr_out == pb + 16'h0001;
  endproperty
  property p_cyc_win;
    req_out && !area_out |-> addr_out >= cb && addr_out <= cb + 16'h0009;
  endproperty
  property p_par_win;
    req_out && area_out |-> addr_out >= pb && addr_out <= pb + 16'h0063;
  endproperty
  property p_unit;
    req_out |-> unit_number_in <= MAX_UNIT;
  endproperty
  property p_bad;
    unit_number_bad_out |-> !req_out && unit_number_in > MAX_UNIT;
  endproperty
  property p_hold;
    req_out && !ack_in |=> req_out && $stable(addr_out) && $stable(we_out) && $stable(wdata_out);
  endproperty
  property p_drop;
    take |=> !req_out;
  endproperty
  property p_clr;
    take && we_out && area_out && addr_out == pb |-> wdata_out == 16'h0000;
  endproperty
  property p_lamp;
    take && we_out && area_out && addr_out == pb + 16'h0011 |=> unit_error_lamp_out == ($past(wdata_out) != 16'h0000);
  endproperty
  property p_dir;
    req_out && !area_out |-> we_out == IS_INPUT;
  endproperty
  a_copy: assert property (p_copy) else $error("copy-back did not follow");
  a_load: assert property (p_load) else $error("load did not follow");
  a_cyc_win: assert property (p_cyc_win) else $error("cyclic address outside block");
  a_par_win: assert property (p_par_win) else $error("parameter address outside block");
  a_unit: assert property (p_unit) else $error("request with bad unit number");
  a_bad: assert property (p_bad) else $error("bad unit flag wrong");
  a_hold: assert property (p_hold) else $error("request changed before ack");
  a_drop: assert property (p_drop) else $error("request held after ack");
  a_clr: assert property (p_clr) else $error("command word not cleared");
  a_lamp: assert property (p_lamp) else $error("lamp disagrees with error word");
  a_dir: assert property (p_dir) else $error("cyclic direction wrong");
endmodule // word_exchange_monitor

bind io_unit_shared_word_exchange word_exchange_monitor #(.IS_INPUT(IS_INPUT)) u_mon (.clock_in, .rst_n_in,
  .restart_in, .unit_number_in, .ack_in, .rdata_in, .req_out, .we_out, .area_out, .addr_out, .wdata_out,
  .unit_error_lamp_out, .unit_number_bad_out);

// *** dv/host_word_memory.sv ***
/* host word memory, two areas of 64k words, one request at a time
   assumes requests stand until acknowledged */
module host_word_memory (
  input wire logic clock_in,
  input wire logic slow_in,
  input wire logic req_in,
  input wire logic we_in,
  input wire logic area_in,
  input wire logic [15:0] addr_in,
  input wire logic [15:0] wdata_in,
  output logic ack_out,
  output logic [15:0] rdata_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] mem [2][65536];
  int wait_cnt = 0;
  initial begin
    ack_out = 1'b0;
    rdata_out = 16'h0000;
    foreach (mem[a, i]) mem[a][i] = 16'h0000;
  end
  always @(posedge clock_in) begin
    ack_out <= 1'b0;
    // read data is only good in the ack cycle
    rdata_out <= ~rdata_out;
    if (req_in && !ack_out) begin
      if (wait_cnt > 0) begin
        wait_cnt <= wait_cnt - 1;
      end else begin
        ack_out <= 1'b1;
        wait_cnt <= slow_in ? $urandom_range(3) : 0;
        if (we_in) mem[area_in][addr_in] <= wdata_in;
        else rdata_out <= mem[area_in][addr_in];
      end
    end
  end
endmodule // host_word_memory

// *** dv/test_io_unit_shared_word_exchange.sv ***
/* self-checking bench for the word-exchange block
   assumes host_word_memory as the host and the bound checker */
module test_io_unit_shared_word_exchange;
  timeunit 1ns;
  timeprecision 100ps;
  import word_exchange_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, restart = 1'b0, slow = 1'b0;
  logic ack, req, we, area, lamp, bad;
  logic [6:0] unit = 7'h00;
  logic [15:0] rdata, addr, wdata, pb, cb;
  logic [15:0] proc [CYC_WORDS];
  logic [15:0] cyc [CYC_WORDS];
  logic ack_o, req_o, we_o, area_o, lamp_o, bad_o;
  logic [15:0] rdata_o, addr_o, wdata_o;
  logic [15:0] cyc_o [CYC_WORDS];
  logic [15:0] exp_st [1:16];
  int fail_count = 0, num_checks = 0, err_seen = 0;
  io_unit_shared_word_exchange u_dut (.clock_in(clk), .rst_n_in(rst_n), .restart_in(restart),
    .unit_number_in(unit), .proc_in(proc), .ack_in(ack), .rdata_in(rdata), .req_out(req), .we_out(we),
    .area_out(area), .addr_out(addr), .wdata_out(wdata), .unit_error_lamp_out(lamp),
    .unit_number_bad_out(bad), .cyc_out(cyc));
  host_word_memory u_host (.clock_in(clk), .slow_in(slow), .req_in(req), .we_in(we), .area_in(area),
    .addr_in(addr), .wdata_in(wdata), .ack_out(ack), .rdata_out(rdata));
  // output-type unit on a host of its own: one unit per host, so both units can take the same unit number
  io_unit_shared_word_exchange #(.IS_INPUT(1'b0)) u_dut_out (.clock_in(clk), .rst_n_in(rst_n),
    .restart_in(restart), .unit_number_in(unit), .proc_in(proc), .ack_in(ack_o), .rdata_in(rdata_o),
    .req_out(req_o), .we_out(we_o), .area_out(area_o), .addr_out(addr_o), .wdata_out(wdata_o),
    .unit_error_lamp_out(lamp_o), .unit_number_bad_out(bad_o), .cyc_out(cyc_o));
  host_word_memory u_host_out (.clock_in(clk), .slow_in(slow), .req_in(req_o), .we_in(we_o),
    .area_in(area_o), .addr_in(addr_o), .wdata_in(wdata_o), .ack_out(ack_o), .rdata_out(rdata_o));
  always #12.5 clk = ~clk;
  always @(posedge clk) if (req && ack && we && area && addr == pb + 16'h0011) err_seen <= err_seen + 1;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask
  // ==========================================
  // stimulus helpers
  task automatic put(input int i, input logic [15:0] v);
    u_host.mem[1][pb + 16'(i)] = v;
  endtask
  task automatic wait_err(input int n);
    int target;
    target = err_seen + n;
    for (int t = 0; t < 9000 && err_seen < target; t++) @(posedge clk);
    if (err_seen < target) begin
      $display("[ERR] %0t error word write missing", $time);
      fail_count++;
    end
    @(negedge clk);
  endtask
  // the restart line stands in for the host's per-unit restart bit
  task automatic boot(input logic [6:0] u, input logic [15:0] cmd, input bit fill);
    @(negedge clk);
    restart = 1'b1;
    unit = u;
    pb = PARAM_BASE + PARAM_STRIDE * {9'h000, u};
    cb = CYCLIC_BASE + CYCLIC_STRIDE * {9'h000, u};
    put(0, cmd);
    for (int i = 1; i <= SET_WORDS && fill; i++) begin
      exp_st[i] = 16'($urandom_range(16'h270F));
      put(i, exp_st[i]);
    end
    @(negedge clk);
    restart = 1'b0;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ==========================================
  // scenarios
  initial begin
    int k;
    int j;
    void'($urandom(32'hC75133A2));
    foreach (proc[i]) proc[i] = 16'($urandom);
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    boot(7'($urandom_range(95)), 16'h0000, 1'b1);
    // with slow off both units run in lockstep, so two passes cover the output unit too
    foreach (proc[i]) u_host_out.mem[0][cb + 16'(i)] = ~proc[i];
    wait_err(3);
    chk(u_host.mem[1][pb + 16'h0011], 16'h0000);
    chk({15'h0000, lamp}, 16'h0000);
    foreach (proc[i]) chk(u_host.mem[0][cb + 16'(i)], proc[i]);
    foreach (proc[i]) chk(cyc_o[i], ~proc[i]);
    slow = 1'b1;
    k = $urandom_range(7, 1);
    put(k, 16'h2710);
    put(8, 16'hFFFF);
    wait_err(2);
    chk(u_host.mem[1][pb + 16'h0011], 16'(k));
    chk({15'h0000, lamp}, 16'h0001);
    put(k, exp_st[k]);
    put(8, exp_st[8]);
    wait_err(2);
    chk(u_host.mem[1][pb + 16'h0011], 16'h0000);
    j = $urandom_range(16, 9);
    put(j, 16'h2710);
    wait_err(2);
    chk(u_host.mem[1][pb + 16'h0011], 16'h0000);
    boot(unit, 16'h0000, 1'b0);
    wait_err(2);
    chk(u_host.mem[1][pb + 16'h0011], 16'(j));
    chk({15'h0000, lamp}, 16'h0001);
    boot(MAX_UNIT, 16'h3039, 1'b0);
    for (int i = 1; i <= SET_WORDS; i++) put(i, ~exp_st[i]);
    wait_err(1);
    chk(u_host.mem[1][pb], 16'h0000);
    for (int i = 1; i <= SET_WORDS; i++) chk(u_host.mem[1][pb + 16'(i)], exp_st[i]);
    boot(7'h60, 16'h0000, 1'b0);
    repeat (20) @(negedge clk);
    chk({15'h0000, bad}, 16'h0001);
    chk({15'h0000, bad_o}, 16'h0001);
    tally_and_finish;
  end
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    tally_and_finish;
  end
endmodule // test_io_unit_shared_word_exchange
